//--- common/pxb_pkg.sv
// Constants, function table and state type of the port crossbar and pin assignment block.
package pxb_pkg;

  localparam int PXB_PINS   = 24;
  localparam int PXB_PORT_W = 8;
  localparam int PXB_FN_N   = 22;

  // Special function register addresses.
  localparam logic [7:0] PXB_A_ROUTE_A = 8'he1;
  localparam logic [7:0] PXB_A_ROUTE_B = 8'he2;
  localparam logic [7:0] PXB_A_PORT0   = 8'h80;
  localparam logic [7:0] PXB_A_PORT1   = 8'h90;
  localparam logic [7:0] PXB_A_PORT2   = 8'ha0;
  localparam logic [7:0] PXB_A_MDIN0   = 8'hf1;
  localparam logic [7:0] PXB_A_MDIN1   = 8'hf2;
  localparam logic [7:0] PXB_A_MDIN2   = 8'hf3;
  localparam logic [7:0] PXB_A_MDOUT0  = 8'ha4;
  localparam logic [7:0] PXB_A_MDOUT1  = 8'ha5;
  localparam logic [7:0] PXB_A_MDOUT2  = 8'ha6;
  localparam logic [7:0] PXB_A_SKIP0   = 8'hd4;
  localparam logic [7:0] PXB_A_SKIP1   = 8'hd5;
  localparam logic [7:0] PXB_A_SKIP2   = 8'hd6;
  localparam logic [7:0] PXB_A_ODEN0   = 8'hb0;

  // Field positions of the first route select register.
  localparam int PXB_RA_ASYNC   = 0;
  localparam int PXB_RA_SPI     = 1;
  localparam int PXB_RA_TWOWIRE = 2;
  localparam int PXB_RA_CLKOUT  = 3;
  localparam int PXB_RA_CP0     = 4;
  localparam int PXB_RA_CP0A    = 5;
  localparam int PXB_RA_CP1     = 6;
  localparam int PXB_RA_CP1A    = 7;

  // Field positions of the second route select register.
  localparam int PXB_RB_CAP_LSB = 0;
  localparam int PXB_RB_CAP_MSB = 2;
  localparam int PXB_RB_ACLK    = 3;
  localparam int PXB_RB_T0      = 4;
  localparam int PXB_RB_T1      = 5;
  localparam int PXB_RB_XBAR_ON = 6;
  localparam int PXB_RB_WEAK_DIS = 7;
  localparam logic [2:0] PXB_CAP_RESERVED = 3'h7;
  localparam int PXB_CAP_N = 6;

  // Fixed pins of the asynchronous serial port.
  localparam int PXB_TX_PIN = 4;
  localparam int PXB_RX_PIN = 5;

  // Function indices; the index order is the crossbar priority order.
  localparam int PXB_FN_TX     = 0;
  localparam int PXB_FN_RX     = 1;
  localparam int PXB_FN_SCK    = 2;
  localparam int PXB_FN_MISO   = 3;
  localparam int PXB_FN_MOSI   = 4;
  localparam int PXB_FN_SSEL   = 5;
  localparam int PXB_FN_SDA    = 6;
  localparam int PXB_FN_SCL    = 7;
  localparam int PXB_FN_CP0    = 8;
  localparam int PXB_FN_CP0A   = 9;
  localparam int PXB_FN_CP1    = 10;
  localparam int PXB_FN_CP1A   = 11;
  localparam int PXB_FN_CLKOUT = 12;
  localparam int PXB_FN_CAP0   = 13;
  localparam int PXB_FN_ACLK   = 19;
  localparam int PXB_FN_T0     = 20;
  localparam int PXB_FN_T1     = 21;

  // Reset values.
  localparam logic [23:0] PXB_LATCH_RST = 24'hffffff;
  localparam logic [23:0] PXB_MDIN_RST  = 24'hffffff;

  typedef struct packed {
    logic [7:0]  route_a;
    logic [7:0]  route_b;
    logic [23:0] latch;
    logic [23:0] mdin;
    logic [23:0] mdout;
    logic [23:0] skip;
    logic [7:0]  oden;
    logic [7:0]  rdata;
    logic [23:0] pad_out;
    logic [23:0] pad_oe;
    logic [23:0] pad_pull;
    logic [21:0] fn_in;
    logic [21:0] fn_placed;
  } pxb_state_t;

  localparam pxb_state_t PXB_STATE_RST = '{
    route_a:   8'h00,
    route_b:   8'h00,
    latch:     PXB_LATCH_RST,
    mdin:      PXB_MDIN_RST,
    mdout:     24'h000000,
    skip:      24'h000000,
    oden:      8'h00,
    rdata:     8'h00,
    pad_out:   24'h000000,
    pad_oe:    24'h000000,
    pad_pull:  24'h000000,
    fn_in:     22'h3fffff,
    fn_placed: 22'h000000
  };

endpackage : pxb_pkg

//--- src/pxb_pin_cell.sv
// Combinational driver and pullup decision of one port pin.
`timescale 1ns/100ps
module pxb_pin_cell (
  input  wire logic xbar_on,
  input  wire logic digital,
  input  wire logic push_pull,
  input  wire logic force_od,
  input  wire logic weak_dis,
  input  wire logic has_fn,
  input  wire logic fn_val,
  input  wire logic fn_drive,
  input  wire logic latch_val,
  output logic      pin_val,
  output logic      pin_drive,
  output logic      pin_pull
);

  logic value;
  logic drive_en;
  logic push;

  always_comb begin
    value     = has_fn ? fn_val : latch_val;
    drive_en  = xbar_on & digital & (has_fn ? fn_drive : 1'b1);
    push      = push_pull & ~force_od;
    // Open-drain drives only the low level; a high value leaves the pin released.
    pin_drive = drive_en & (push | ~value);
    pin_val   = value & push;
    pin_pull  = digital & ~weak_dis & ~push & ~(drive_en & ~value);
  end

endmodule : pxb_pin_cell

//--- src/pxb_crossbar.sv
// Priority crossbar decoder with per-pin configuration registers for three 8-bit ports.
`timescale 1ns/100ps
module pxb_crossbar (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [7:0]                    sfr_addr,
  input  wire logic                          sfr_wr,
  input  wire logic [7:0]                    sfr_wdata,
  input  wire logic                          sfr_rd,
  output logic      [7:0]                    sfr_rdata,
  input  wire logic                          ssel_four_wire,
  input  wire logic [pxb_pkg::PXB_PINS-1:0]  pad_in,
  output logic      [pxb_pkg::PXB_PINS-1:0]  pad_out,
  output logic      [pxb_pkg::PXB_PINS-1:0]  pad_oe,
  output logic      [pxb_pkg::PXB_PINS-1:0]  pad_pullup,
  output logic      [pxb_pkg::PXB_PINS-1:0]  pad_rx_en,
  output logic      [7:0]                    overdrive_mode_mask,
  input  wire logic [pxb_pkg::PXB_FN_N-1:0]  fn_out,
  input  wire logic [pxb_pkg::PXB_FN_N-1:0]  fn_oe,
  output logic      [pxb_pkg::PXB_FN_N-1:0]  fn_in,
  output logic      [pxb_pkg::PXB_FN_N-1:0]  fn_placed
);
  import pxb_pkg::*;

  pxb_state_t s_q;
  pxb_state_t s_d;

  logic                xbar_on;
  logic [PXB_FN_N-1:0] fn_en;
  logic [PXB_FN_N-1:0] fn_ok;
  logic [4:0]          fn_pin [PXB_FN_N];
  logic [PXB_PINS-1:0] taken;
  logic [PXB_PINS-1:0] pin_has_fn;
  logic [PXB_PINS-1:0] pin_fn_val;
  logic [PXB_PINS-1:0] pin_fn_drive;
  logic [PXB_PINS-1:0] pin_force_od;
  logic [PXB_PINS-1:0] pin_rx;
  logic [PXB_PINS-1:0] cell_val;
  logic [PXB_PINS-1:0] cell_drive;
  logic [PXB_PINS-1:0] cell_pull;
  logic                found;

  assign xbar_on = s_q.route_b[PXB_RB_XBAR_ON];
  // An analog pin has its receiver off and reads as zero.
  assign pin_rx  = pad_in & s_q.mdin;

  // Enabled functions in priority order.
  always_comb begin
    fn_en                = '0;
    fn_en[PXB_FN_TX]     = s_q.route_a[PXB_RA_ASYNC];
    fn_en[PXB_FN_RX]     = s_q.route_a[PXB_RA_ASYNC];
    fn_en[PXB_FN_SCK]    = s_q.route_a[PXB_RA_SPI];
    fn_en[PXB_FN_MISO]   = s_q.route_a[PXB_RA_SPI];
    fn_en[PXB_FN_MOSI]   = s_q.route_a[PXB_RA_SPI];
    fn_en[PXB_FN_SSEL]   = s_q.route_a[PXB_RA_SPI] & ssel_four_wire;
    fn_en[PXB_FN_SDA]    = s_q.route_a[PXB_RA_TWOWIRE];
    fn_en[PXB_FN_SCL]    = s_q.route_a[PXB_RA_TWOWIRE];
    fn_en[PXB_FN_CP0]    = s_q.route_a[PXB_RA_CP0];
    fn_en[PXB_FN_CP0A]   = s_q.route_a[PXB_RA_CP0A];
    fn_en[PXB_FN_CP1]    = s_q.route_a[PXB_RA_CP1];
    fn_en[PXB_FN_CP1A]   = s_q.route_a[PXB_RA_CP1A];
    fn_en[PXB_FN_CLKOUT] = s_q.route_a[PXB_RA_CLKOUT];
    // The reserved code of the capture field routes no channel.
    for (int k = 0; k < PXB_CAP_N; k++) begin
      fn_en[PXB_FN_CAP0 + k] = (s_q.route_b[PXB_RB_CAP_MSB:PXB_RB_CAP_LSB] > 3'(k)) &&
                               (s_q.route_b[PXB_RB_CAP_MSB:PXB_RB_CAP_LSB]
                                != PXB_CAP_RESERVED);
    end
    fn_en[PXB_FN_ACLK]   = s_q.route_b[PXB_RB_ACLK];
    fn_en[PXB_FN_T0]     = s_q.route_b[PXB_RB_T0];
    fn_en[PXB_FN_T1]     = s_q.route_b[PXB_RB_T1];
    fn_en                = fn_en & {PXB_FN_N{xbar_on}};
  end

  // Priority walk; a function that finds no free pin is left unplaced.
  always_comb begin
    taken = s_q.skip;
    fn_ok = '0;
    found = 1'b0;
    for (int f = 0; f < PXB_FN_N; f++) begin
      fn_pin[f] = 5'h00;
    end
    if (fn_en[PXB_FN_TX]) begin
      fn_ok[PXB_FN_TX]     = 1'b1;
      fn_ok[PXB_FN_RX]     = 1'b1;
      fn_pin[PXB_FN_TX]    = 5'(PXB_TX_PIN);
      fn_pin[PXB_FN_RX]    = 5'(PXB_RX_PIN);
      taken[PXB_TX_PIN]    = 1'b1;
      taken[PXB_RX_PIN]    = 1'b1;
    end
    for (int f = PXB_FN_SCK; f < PXB_FN_N; f++) begin
      found = 1'b0;
      // The two-wire pair is placed whole or not at all, so a lone data pin never appears.
      if (fn_en[f] && !((f == PXB_FN_SDA) && ($countones(~taken) < 2))
                   && !((f == PXB_FN_SCL) && !fn_ok[PXB_FN_SDA])) begin
        for (int p = 0; p < PXB_PINS; p++) begin
          if (!found && !taken[p]) begin
            found     = 1'b1;
            taken[p]  = 1'b1;
            fn_pin[f] = 5'(p);
          end
        end
      end
      fn_ok[f] = found;
    end
  end

  // Per-pin view of the assignment; pins with no function stay general I/O.
  always_comb begin
    pin_has_fn   = '0;
    pin_fn_val   = '0;
    pin_fn_drive = '0;
    pin_force_od = '0;
    for (int f = 0; f < PXB_FN_N; f++) begin
      if (fn_ok[f]) begin
        pin_has_fn[fn_pin[f]]   = 1'b1;
        pin_fn_val[fn_pin[f]]   = fn_out[f];
        pin_fn_drive[fn_pin[f]] = fn_oe[f];
        if (f == PXB_FN_SDA || f == PXB_FN_SCL) begin
          pin_force_od[fn_pin[f]] = 1'b1;
        end
      end
    end
  end

  // One cell per pin across all three ports.
  for (genvar g = 0; g < PXB_PINS; g++) begin : g_pin
    pxb_pin_cell u_cell (
      .xbar_on   (xbar_on),
      .digital   (s_q.mdin[g]),
      .push_pull (s_q.mdout[g]),
      .force_od  (pin_force_od[g]),
      .weak_dis  (s_q.route_b[PXB_RB_WEAK_DIS]),
      .has_fn    (pin_has_fn[g]),
      .fn_val    (pin_fn_val[g]),
      .fn_drive  (pin_fn_drive[g]),
      .latch_val (s_q.latch[g]),
      .pin_val   (cell_val[g]),
      .pin_drive (cell_drive[g]),
      .pin_pull  (cell_pull[g])
    );
  end

  // Register writes, reads and the registered pin and function outputs.
  always_comb begin
    s_d           = s_q;
    s_d.pad_out   = cell_val;
    s_d.pad_oe    = cell_drive;
    s_d.pad_pull  = cell_pull;
    s_d.fn_placed = fn_ok;
    for (int f = 0; f < PXB_FN_N; f++) begin
      // Unplaced inputs idle high so that a peripheral sees an inactive line.
      s_d.fn_in[f] = fn_ok[f] ? pin_rx[fn_pin[f]] : 1'b1;
    end
    if (sfr_wr) begin
      unique case (sfr_addr)
        PXB_A_ROUTE_A: s_d.route_a      = sfr_wdata;
        PXB_A_ROUTE_B: s_d.route_b      = sfr_wdata;
        PXB_A_PORT0:   s_d.latch[7:0]   = sfr_wdata;
        PXB_A_PORT1:   s_d.latch[15:8]  = sfr_wdata;
        PXB_A_PORT2:   s_d.latch[23:16] = sfr_wdata;
        PXB_A_MDIN0:   s_d.mdin[7:0]    = sfr_wdata;
        PXB_A_MDIN1:   s_d.mdin[15:8]   = sfr_wdata;
        PXB_A_MDIN2:   s_d.mdin[23:16]  = sfr_wdata;
        PXB_A_MDOUT0:  s_d.mdout[7:0]   = sfr_wdata;
        PXB_A_MDOUT1:  s_d.mdout[15:8]  = sfr_wdata;
        PXB_A_MDOUT2:  s_d.mdout[23:16] = sfr_wdata;
        PXB_A_SKIP0:   s_d.skip[7:0]    = sfr_wdata;
        PXB_A_SKIP1:   s_d.skip[15:8]   = sfr_wdata;
        PXB_A_SKIP2:   s_d.skip[23:16]  = sfr_wdata;
        PXB_A_ODEN0:   s_d.oden         = sfr_wdata;
        default:       s_d.oden         = s_q.oden;
      endcase
    end
    if (sfr_rd) begin
      unique case (sfr_addr)
        PXB_A_ROUTE_A: s_d.rdata = s_q.route_a;
        PXB_A_ROUTE_B: s_d.rdata = s_q.route_b;
        PXB_A_PORT0:   s_d.rdata = pin_rx[7:0];
        PXB_A_PORT1:   s_d.rdata = pin_rx[15:8];
        PXB_A_PORT2:   s_d.rdata = pin_rx[23:16];
        PXB_A_MDIN0:   s_d.rdata = s_q.mdin[7:0];
        PXB_A_MDIN1:   s_d.rdata = s_q.mdin[15:8];
        PXB_A_MDIN2:   s_d.rdata = s_q.mdin[23:16];
        PXB_A_MDOUT0:  s_d.rdata = s_q.mdout[7:0];
        PXB_A_MDOUT1:  s_d.rdata = s_q.mdout[15:8];
        PXB_A_MDOUT2:  s_d.rdata = s_q.mdout[23:16];
        PXB_A_SKIP0:   s_d.rdata = s_q.skip[7:0];
        PXB_A_SKIP1:   s_d.rdata = s_q.skip[15:8];
        PXB_A_SKIP2:   s_d.rdata = s_q.skip[23:16];
        PXB_A_ODEN0:   s_d.rdata = s_q.oden;
        default:       s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= PXB_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata           = s_q.rdata;
  assign pad_out             = s_q.pad_out;
  assign pad_oe              = s_q.pad_oe;
  assign pad_pullup          = s_q.pad_pull;
  assign pad_rx_en           = s_q.mdin;
  assign overdrive_mode_mask = s_q.oden;
  assign fn_in               = s_q.fn_in;
  assign fn_placed           = s_q.fn_placed;

  // Checks on the driven outputs and on the internal placement decode.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_xbar_off_write;
    sfr_wr && (sfr_addr == PXB_A_ROUTE_B) && !sfr_wdata[PXB_RB_XBAR_ON];
  endsequence

  sequence s_uart_tx_ready;
    xbar_on && s_q.route_a[PXB_RA_ASYNC] && s_q.mdin[PXB_TX_PIN] && s_q.mdout[PXB_TX_PIN] &&
    fn_oe[PXB_FN_TX];
  endsequence

  sequence s_port0_read;
    sfr_rd && (sfr_addr == PXB_A_PORT0);
  endsequence

  AST_XBAR_OFF_DRIVERS: assert property (s_xbar_off_write |=> ##1 (pad_oe == '0))
    else $error("Pin driver active after crossbar was disabled.");

  AST_XBAR_OFF_NO_FN: assert property (!xbar_on |=> (fn_placed == '0))
    else $error("Function placed while crossbar disabled.");

  AST_ANALOG_OFF: assert property (
      1'b1 |=> (((pad_oe | pad_pullup) & ~$past(s_q.mdin)) == '0))
    else $error("Analog pin has driver or pullup enabled.");

  AST_UART_FIXED: assert property (
      s_uart_tx_ready |=>
      (pad_oe[PXB_TX_PIN] && (pad_out[PXB_TX_PIN] == $past(fn_out[PXB_FN_TX]))))
    else $error("Serial transmit not on its fixed pin.");

  AST_PULL_LOW_OFF: assert property ((pad_pullup & pad_oe & ~pad_out) == '0)
    else $error("Pullup on while pin drives low.");

  AST_WEAK_DIS: assert property (s_q.route_b[PXB_RB_WEAK_DIS] |=> (pad_pullup == '0))
    else $error("Pullup on while weak pullups disabled.");

  AST_TWOWIRE_OD: assert property (
      1'b1 |=> ((pad_oe & pad_out & $past(pin_force_od)) == '0))
    else $error("Two-wire pin driven high.");

  AST_SKIP_RESPECTED: assert property (
      ((pin_has_fn & s_q.skip & ~(24'(3) << PXB_TX_PIN)) == '0))
    else $error("Function placed on a skipped pin.");

  AST_SSEL_THREE_WIRE: assert property (!ssel_four_wire |=> !fn_placed[PXB_FN_SSEL])
    else $error("Slave select placed in three-wire operation.");

  AST_PORT_READ: assert property (
      s_port0_read |=> (sfr_rdata == $past(pad_in[7:0] & s_q.mdin[7:0])))
    else $error("Port read did not return pin levels.");

  AST_TWOWIRE_PAIR: assert property (
      (fn_ok[PXB_FN_SDA] == fn_ok[PXB_FN_SCL]) || !fn_en[PXB_FN_SCL])
    else $error("Two-wire pins placed apart.");

  // The capture field is pulled out as a plain vector for the checks below.
  logic [2:0] cap_sel;
  assign cap_sel = s_q.route_b[PXB_RB_CAP_MSB:PXB_RB_CAP_LSB];

  AST_RESET_STATE: assert property (
      $fell(rst) |-> ((pad_rx_en == '1) && (pad_oe == '0) && (fn_placed == '0)))
    else $error("Pins not digital inputs after reset.");

  AST_TXRX_PAIR: assert property (
      fn_en[PXB_FN_TX] |=> (fn_placed[PXB_FN_TX] && fn_placed[PXB_FN_RX]))
    else $error("Serial port pins not placed together.");

  AST_RX_ROUTED: assert property (
      fn_ok[PXB_FN_RX] |=> (fn_in[PXB_FN_RX] == $past(pin_rx[PXB_RX_PIN])))
    else $error("Serial receive not taken from its fixed pin.");

  AST_PIN_UNIQUE: assert property (
      $countones(fn_ok) == $countones(pin_has_fn))
    else $error("Two functions placed on one pin.");

  AST_ONLY_SELECTED: assert property (
      (fn_ok & ~fn_en) == '0)
    else $error("Function placed without being selected.");

  AST_SPI_PINS: assert property (
      (xbar_on && s_q.route_a[PXB_RA_SPI]) |->
      ($countones(fn_en[PXB_FN_SCK +: 4]) == (ssel_four_wire ? 4 : 3)))
    else $error("Serial peripheral pin count wrong for its wire mode.");

  AST_CAP_RESERVED: assert property (
      (cap_sel == PXB_CAP_RESERVED) |=> (fn_placed[PXB_FN_CAP0 +: PXB_CAP_N] == '0))
    else $error("Reserved capture code routed a channel.");

  AST_CAP_COUNT: assert property (
      (xbar_on && (cap_sel != PXB_CAP_RESERVED)) |->
      ($countones(fn_en[PXB_FN_CAP0 +: PXB_CAP_N]) == cap_sel))
    else $error("Capture channel count differs from the field.");

  AST_OD_NEVER_HIGH: assert property (
      1'b1 |=> ((pad_out & ~$past(s_q.mdout)) == '0))
    else $error("Open-drain pin drives a high level.");

  AST_GPIO_DRIVEN: assert property (
      xbar_on |=> ((~pad_oe & $past(~pin_has_fn & s_q.mdin & s_q.mdout)) == '0))
    else $error("Push-pull general pin not driven with crossbar on.");

  AST_GPIO_LEVEL: assert property (
      1'b1 |=> (((pad_out ^ $past(s_q.latch)) & $past(~pin_has_fn & s_q.mdout)) == '0))
    else $error("General pin does not show its latch.");

endmodule : pxb_crossbar

//--- tb/pxb_board_model.sv
// Board-side model that resolves each port pin from the block's drivers, pullups and the outside world.
`timescale 1ns/100ps
module pxb_board_model (
  input  wire logic        clk,
  input  wire logic [23:0] pad_out,
  input  wire logic [23:0] pad_oe,
  input  wire logic [23:0] pad_pullup,
  input  wire logic [23:0] ext_val,
  input  wire logic [23:0] ext_en,
  output logic      [23:0] pad_in
);
  logic [23:0] float_q = 24'h5a5a5a;

  // A pin nobody drives or pulls toggles each cycle, so no check can lean on a settled unknown.
  always @(posedge clk) begin
    float_q <= ~float_q;
  end

  // The block's own driver beats the outside source; the weak pullup only counts when both let go.
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                  pad_pullup[i] ? 1'b1 : float_q[i];
    end
  end
endmodule : pxb_board_model

//--- tb/tb_port_crossbar_pin_assign.sv
// Self-checking testbench of the port crossbar and pin assignment block.
`timescale 1ns/100ps
module tb_port_crossbar_pin_assign;
  import pxb_pkg::*;
  logic        clk, rst, sfr_wr, sfr_rd, ssel_four_wire;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rd_val, od_mask;
  logic [23:0] pad_in, pad_out, pad_oe, pad_pullup, pad_rx_en, ext_val, ext_en;
  logic [21:0] fn_out, fn_oe, fn_in, fn_placed;
  int          mismatches, checked;

  pxb_crossbar dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .ssel_four_wire(ssel_four_wire), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .pad_rx_en(pad_rx_en), .overdrive_mode_mask(od_mask),
    .fn_out(fn_out), .fn_oe(fn_oe), .fn_in(fn_in), .fn_placed(fn_placed));

  pxb_board_model board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge clk);
    #1;
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd

  // Configuration changes reach the pins one edge after wr returns; two more edges of margin.
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  // Output modes, then skips, then function selects, then the enable register last.
  task automatic cfg(input logic [7:0] ra, input logic [7:0] rb, input logic [7:0] md0,
                     input logic [7:0] sk0);
    wr(PXB_A_MDOUT0, md0);
    wr(PXB_A_SKIP0, sk0);
    wr(PXB_A_ROUTE_A, ra);
    wr(PXB_A_ROUTE_B, rb);
    settle;
  endtask : cfg

  // A function sees exactly the pin it was given: drive that pin alone high, then alone low.
  task automatic map(input int f, input int p);
    ext_val = 24'h000001 << p;
    settle;
    chk("fn_in high", 24'(fn_in[f]), 24'h000001);
    ext_val = ~(24'h000001 << p);
    settle;
    chk("fn_in low", 24'(fn_in[f]), 24'h000000);
  endtask : map

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  initial begin
    #(40 * 5000);
    mismatches++;
    finish_test;
  end

  initial begin
    rst = 1'b1;
    {sfr_wr, sfr_rd, ssel_four_wire} = 3'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    fn_out = 22'h000000;
    fn_oe = 22'h000000;
    ext_val = 24'h3c5a00;
    ext_en = 24'hffffff;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    // Reset values, unmapped read, port read and analog pins.
    rd(PXB_A_ROUTE_A, rd_val);
    chk("route_a", 24'(rd_val), 24'h000000);
    rd(PXB_A_MDIN0, rd_val);
    chk("mdin0", 24'(rd_val), 24'h0000ff);
    rd(8'h00, rd_val);
    chk("unmapped", 24'(rd_val), 24'h000000);
    chk("rx_en", pad_rx_en, 24'hffffff);
    chk("oe off", pad_oe, 24'h000000);
    rd(PXB_A_PORT1, rd_val);
    chk("port1", 24'(rd_val), 24'h00005a);
    wr(PXB_A_MDIN1, 8'h0f);
    settle;
    rd(PXB_A_PORT1, rd_val);
    chk("port1 analog", 24'(rd_val), 24'h00000a);
    chk("rx analog", 24'(pad_rx_en[15:8]), 24'h00000f);
    chk("pull analog", 24'(pad_pullup[15:12]), 24'h000000);
    wr(PXB_A_MDIN1, 8'hff);
    wr(PXB_A_ODEN0, 8'ha5);
    chk("oden", 24'(od_mask), 24'h0000a5);
    $display("test reset done");
    // Crossbar off ignores selections and drivers; on gives port outputs.
    wr(PXB_A_PORT0, 8'h00);
    cfg(8'hff, 8'h00, 8'hff, 8'h00);
    chk("placed off", 24'(fn_placed), 24'h000000);
    chk("oe off", pad_oe, 24'h000000);
    cfg(8'h00, 8'h40, 8'hff, 8'h00);
    chk("gpio oe", 24'(pad_oe[7:0]), 24'h0000ff);
    chk("gpio out", 24'(pad_out[7:0]), 24'h000000);
    wr(PXB_A_PORT0, 8'hff);
    settle;
    chk("gpio out hi", 24'(pad_out[7:0]), 24'h0000ff);
    $display("test enable done");
    // Serial port and SPI around skipped pins.
    ssel_four_wire = 1'b1;
    cfg(8'h03, 8'h40, 8'hff, 8'h03);
    chk("placed spi4", 24'(fn_placed), 24'h00003f);
    map(PXB_FN_TX, 4);
    map(PXB_FN_RX, 5);
    map(PXB_FN_SCK, 2);
    map(PXB_FN_MISO, 3);
    map(PXB_FN_MOSI, 6);
    map(PXB_FN_SSEL, 7);
    fn_oe[PXB_FN_TX] = 1'b1;
    settle;
    chk("tx oe", 24'(pad_oe[4]), 24'h000001);
    chk("tx low", 24'(pad_out[4]), 24'h000000);
    fn_out[PXB_FN_TX] = 1'b1;
    settle;
    chk("tx high", 24'(pad_out[4]), 24'h000001);
    wr(PXB_A_MDOUT0, 8'h00);
    settle;
    chk("tx od", 24'(pad_oe[4]), 24'h000000);
    ssel_four_wire = 1'b0;
    settle;
    chk("placed spi3", 24'(fn_placed), 24'h00001f);
    fn_oe = 22'h000000;
    fn_out = 22'h000000;
    $display("test serial done");
    // Two-wire pins are open-drain whatever the output mode says.
    cfg(8'h04, 8'h40, 8'hff, 8'h00);
    chk("placed smb", 24'(fn_placed), 24'h0000c0);
    map(PXB_FN_SDA, 0);
    map(PXB_FN_SCL, 1);
    fn_oe[PXB_FN_SDA] = 1'b1;
    settle;
    chk("sda oe", 24'(pad_oe[0]), 24'h000001);
    chk("sda pull low", 24'(pad_pullup[0]), 24'h000000);
    fn_out[PXB_FN_SDA] = 1'b1;
    settle;
    chk("sda rel", 24'(pad_oe[0]), 24'h000000);
    chk("pullups", 24'(pad_pullup[7:0]), 24'h000003);
    wr(PXB_A_ROUTE_B, 8'hc0);
    settle;
    chk("pull dis", 24'(pad_pullup[7:0]), 24'h000000);
    fn_oe = 22'h000000;
    $display("test twowire done");
    // Capture field, reserved code and the input routes.
    cfg(8'h00, 8'h46, 8'hff, 8'h00);
    chk("cap six", 24'(fn_placed), 24'h07e000);
    wr(PXB_A_ROUTE_B, 8'h7f);
    settle;
    chk("cap resv", 24'(fn_placed), 24'h380000);
    $display("test capture done");
    // Only one free pin for many functions.
    ssel_four_wire = 1'b1;
    wr(PXB_A_SKIP1, 8'hff);
    wr(PXB_A_SKIP2, 8'hfe);
    cfg(8'hff, 8'h7e, 8'hff, 8'hff);
    chk("overflow", 24'(fn_placed), 24'h000007);
    map(PXB_FN_SCK, 16);
    $display("test overflow done");
    finish_test;
  end
endmodule : tb_port_crossbar_pin_assign
